// [hw/interrupt_trap_prioritizer.sv]
// interrupt and trap prioritizer with its wishbone register file
// Operation
// - each source priority lives in the low three bits of its nibble
// - the top bit of every priority nibble reads as zero
// - priority zero is lowest, seven is highest
// - equal priorities are resolved by vector order, only then
// - natural rank equals interrupt number, zero ranks highest
// - vector number is interrupt number plus eight; 45..53 unused
// - reset restarts the core at address zero, bypassing this block
// - watchdog, bad pointer, bad opcode, brown-out or lockout resets
// - a bad opcode flushed before execution causes no reset
// - traps are unmaskable and wait for the instruction to finish
// - trap levels run 8 to 15, so the level top bit is set
// - cpu level seven blocks all interrupts but no trap
// - divide by zero aborts the divide and raises the math trap
// - enabled overflow at bit 31 or 39, or big shift, raise math
// - misaligned, unimplemented, vector fetch or bad jump: address trap
// - split mac access into the other space counts as unimplemented
// - stack pointer above limit or below 0x0800 raises stack trap
// - oscillator failure raises the oscillator trap
// - traps arriving together are served in fixed order
// - math is soft at 11; address 12, stack 13, osc 14 are hard
// - hard traps halt until acknowledged; lower one late is conflict
// - a conflict resets the device and sets the conflict flag
// - interrupt only when priority exceeds the cpu level
// - nesting disable refuses any interrupt while one is in service
// - flags set on their event whatever the enable
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module interrupt_trap_prioritizer (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire logic                     cyc_i,
	input  wire logic                     stb_i,
	input  wire logic                     we_i,
	input  wire logic [7:0]               adr_i,
	input  wire logic [3:0]               sel_i,
	input  wire logic [31:0]              dat_i,
	output logic      [31:0]              dat_o,
	output logic                          ack_o,
	input  wire logic [44:0]              irq_src_i,
	input  wire logic [3:0]               cpu_level_i,
	input  wire logic                     in_service_i,
	input  wire logic                     instr_done_i,
	input  wire logic                     trap_ack_i,
	input  wire logic                     trap_done_i,
	input  wire irq_trap_pkg::fault_t     fault_i,
	output irq_trap_pkg::core_req_t       core_o
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [47:0][2:0]        prio;
		logic [44:0]             en;
		logic                    nesting_disable;
		logic                    ovf31_en;
		logic                    ovf39_en;
		logic [15:0]             stack_limit_value;
		logic [3:0]              tpend;
		logic [3:0]              serve;
		logic                    ack;
		logic [31:0]             rdata;
		irq_trap_pkg::core_req_t out;
	} st_t;
	localparam st_t ST_RST = '{
		prio:  {irq_trap_pkg::NPRIO{irq_trap_pkg::PRIO_RST}},
		stack_limit_value: irq_trap_pkg::STACK_LIMIT_VALUE_RST,
		default: '0
	};
	st_t s;
	st_t next_s;

	// highest set bit as a one-hot mask
	function automatic logic [3:0] top1(input logic [3:0] v);
		top1 = v[3] ? 4'h8 : v[2] ? 4'h4 : v[1] ? 4'h2 : v[0] ? 4'h1
			: 4'h0;
	endfunction
	// index of the highest set bit
	function automatic logic [1:0] enc(input logic [3:0] v);
		enc = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
	endfunction

	// ==========================================================
	// bus decode
	logic [5:0]  idx;
	logic        take;
	logic        wr;
	logic [31:0] bm;
	assign idx  = adr_i[7:2];
	assign take = cyc_i && stb_i && !s.ack;
	// a write lands on the edge where ack is sampled high
	assign wr   = cyc_i && stb_i && we_i && s.ack;
	assign bm   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
		{8{sel_i[0]}}};

	// ==========================================================
	// request flags and arbitration
	logic [44:0]      flags;
	logic [44:0]      flag_set;
	logic [44:0]      flag_clr;
	logic [44:0]      pend;
	logic             found;
	logic [5:0]       num;
	logic [2:0]       lvl;
	// reserved numbers can never be flagged
	assign flag_set = irq_src_i & irq_trap_pkg::SRC_IMPL;
	// write one to clear
	assign flag_clr[31:0]  = (wr && idx == irq_trap_pkg::IDX_FLAG_LO)
		? (dat_i & bm) : 32'h0;
	assign flag_clr[44:32] = (wr && idx == irq_trap_pkg::IDX_FLAG_HI)
		? (dat_i[12:0] & bm[12:0]) : 13'h0;
	assign pend = flags & s.en & irq_trap_pkg::SRC_IMPL;

	sticky_flags #(.W(45)) u_flags (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.set_i (flag_set),
		.clr_i (flag_clr),
		.q_o   (flags)
	);

	irq_arbiter u_arb (
		.req_i   (pend),
		.prio_i  (s.prio),
		.found_o (found),
		.num_o   (num),
		.lvl_o   (lvl)
	);

	// ==========================================================
	// trap detection
	logic [3:0] tev;
	logic [3:0] held;
	logic       mac_bad;
	logic       conflict;
	// a mac access into the other data space is unimplemented
	assign mac_bad = (fault_i.mac_x && fault_i.in_y)
		|| (fault_i.mac_y && fault_i.in_x);
	assign tev[irq_trap_pkg::T_MATH] = fault_i.div_zero
		|| (s.ovf31_en && fault_i.acc_ovf31 && !fault_i.guard_used)
		|| (s.ovf39_en && fault_i.acc_ovf39 && !fault_i.sat_on)
		|| fault_i.shift_over;
	assign tev[irq_trap_pkg::T_ADDR] = fault_i.misalign
		|| fault_i.unimpl_data || fault_i.unimpl_prog
		|| fault_i.vec_fetch || fault_i.bad_branch
		|| fault_i.bad_pc || mac_bad;
	assign tev[irq_trap_pkg::T_STACK] = fault_i.sp_load
		&& (fault_i.sp_value > s.stack_limit_value
		|| fault_i.sp_value < irq_trap_pkg::STACK_FLOOR);
	assign tev[irq_trap_pkg::T_OSC] = fault_i.osc_fail;
	// traps already pending, acknowledged or running, the soft math trap included
	assign held = s.tpend | s.serve;
	// a lower hard trap behind a higher one locks the core out
	assign conflict = (tev[irq_trap_pkg::T_ADDR] && |held[3:2])
		|| (tev[irq_trap_pkg::T_STACK] && held[3]);

	// ==========================================================
	// reset causes, sticky until software clears them
	logic [7:0] cause_set;
	logic [7:0] cause_clr;
	logic [7:0] cause;
	logic       dev_rst;
	always_comb begin
		cause_set = 8'h00;
		cause_set[irq_trap_pkg::CAUSE_WDT]    = fault_i.wdt;
		cause_set[irq_trap_pkg::CAUSE_UNINIT] = fault_i.uninit_w;
		// a flushed opcode never executed, so no reset
		cause_set[irq_trap_pkg::CAUSE_ILL] = fault_i.ill_exec
			&& !fault_i.ill_flushed;
		cause_set[irq_trap_pkg::CAUSE_BOR]  = fault_i.brown_out;
		cause_set[irq_trap_pkg::CAUSE_CONF] = conflict;
	end
	assign cause_clr = (wr && idx == irq_trap_pkg::IDX_STAT && sel_i[1])
		? dat_i[15:8] : 8'h00;
	assign dev_rst = |cause_set;

	sticky_flags #(.W(8)) u_cause (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.set_i (cause_set),
		.clr_i (cause_clr),
		.q_o   (cause)
	);

	// ==========================================================
	// next state: bus, registers, traps and core requests
	always_comb begin
		logic [31:0] rd;
		int          b;
		rd     = 32'h0;
		b      = 0;
		next_s = s;
		// read mux, unmapped words read zero
		if (idx < 6'(irq_trap_pkg::NGRP)) begin
			for (int k = 0; k < 4; k++) begin
				b = int'(idx) * 4 + k;
				rd[4*k +: 3] = s.prio[b];
			end
		end else begin
			case (idx)
				irq_trap_pkg::IDX_FLAG_LO: rd = flags[31:0];
				irq_trap_pkg::IDX_FLAG_HI: rd = {19'h0, flags[44:32]};
				irq_trap_pkg::IDX_EN_LO:   rd = s.en[31:0];
				irq_trap_pkg::IDX_EN_HI:   rd = {19'h0, s.en[44:32]};
				irq_trap_pkg::IDX_CTRL:    rd = {29'h0, s.ovf39_en,
					s.ovf31_en, s.nesting_disable};
				irq_trap_pkg::IDX_STAT:    rd = {16'h0, cause, s.serve,
					s.tpend};
				irq_trap_pkg::IDX_STACK_LIMIT_VALUE:   rd = {16'h0, s.stack_limit_value};
				default:                   rd = 32'h0;
			endcase
		end
		// one wait state, ack drops the cycle after
		next_s.ack = take;
		if (take) begin
			next_s.rdata = rd;
		end
		// register writes honour the byte lanes
		if (wr && idx < 6'(irq_trap_pkg::NGRP)) begin
			for (int k = 0; k < 4; k++) begin
				b = int'(idx) * 4 + k;
				if (sel_i[k / 2]) begin
					next_s.prio[b] = dat_i[4*k +: 3];
				end
			end
		end
		if (wr && idx == irq_trap_pkg::IDX_EN_LO) begin
			next_s.en[31:0] = (s.en[31:0] & ~bm) | (dat_i & bm);
		end
		if (wr && idx == irq_trap_pkg::IDX_EN_HI) begin
			next_s.en[44:32] = (s.en[44:32] & ~bm[12:0])
				| (dat_i[12:0] & bm[12:0]);
		end
		if (wr && idx == irq_trap_pkg::IDX_CTRL && sel_i[0]) begin
			next_s.nesting_disable   = dat_i[irq_trap_pkg::CTRL_NEST];
			next_s.ovf31_en = dat_i[irq_trap_pkg::CTRL_OVF31];
			next_s.ovf39_en = dat_i[irq_trap_pkg::CTRL_OVF39];
		end
		if (wr && idx == irq_trap_pkg::IDX_STACK_LIMIT_VALUE) begin
			next_s.stack_limit_value = (s.stack_limit_value & ~bm[15:0]) | (dat_i[15:0] & bm[15:0]);
		end
		// acknowledge moves the top trap into service
		if (trap_ack_i && |s.tpend) begin
			next_s.tpend = s.tpend & ~top1(s.tpend);
			next_s.serve = s.serve | top1(s.tpend);
		end else if (trap_done_i) begin
			next_s.serve = s.serve & ~top1(s.serve);
		end
		// traps cannot be masked; a new one beats its own ack
		next_s.tpend = next_s.tpend | tev;
		if (dev_rst) begin
			next_s.tpend = 4'h0;
			next_s.serve = 4'h0;
		end
		// an interrupt must beat the cpu level, so seven blocks all
		next_s.out.irq = found && ({1'b0, lvl} > cpu_level_i)
			&& !(s.nesting_disable && in_service_i)
			&& !dev_rst && !s.out.dreset;
		next_s.out.vec = num + irq_trap_pkg::VEC_BASE;
		next_s.out.lvl = lvl;
		// a trap is offered only at an instruction boundary
		next_s.out.treq = |next_s.tpend && instr_done_i
			&& !dev_rst;
		next_s.out.tlvl = irq_trap_pkg::TRAP_LVL_BASE
			+ {2'h0, enc(next_s.tpend)};
		next_s.out.halt = |next_s.tpend[3:1];
		next_s.out.tflag = |next_s.serve;
		next_s.out.dreset = dev_rst;
		next_s.out.div_abort = fault_i.div_zero;
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= ST_RST;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign dat_o  = s.rdata;
	assign ack_o  = s.ack;
	assign core_o = s.out;

	// ==========================================================
	// checks
	nibble_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && !we_i && adr_i[7:2] < 6'h0C
		|-> (dat_o & 32'h0000_8888) == 32'h0)
		else $error("priority nibble top bit not zero");
	above_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && !$past(rst_i) && core_o.irq
		|-> {1'b0, core_o.lvl} > $past(cpu_level_i))
		else $error("interrupt not above cpu level");
	nest_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && s.nesting_disable && in_service_i ##1 1'b1 |-> !core_o.irq)
		else $error("nested interrupt while nesting disabled");
	vector_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_o.irq |-> core_o.vec >= 6'h08 && core_o.vec <= 6'h34)
		else $error("vector outside source range");
	reserved_never_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_o.irq |-> irq_trap_pkg::SRC_IMPL[core_o.vec - 6'h08])
		else $error("reserved source requested");
	trap_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_o.treq |-> core_o.tlvl[3] && core_o.tlvl >= 4'hB)
		else $error("trap level below eight");
	conflict_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && conflict |=> core_o.dreset && !core_o.irq
		&& cause[irq_trap_pkg::CAUSE_CONF])
		else $error("conflict without reset");
	hard_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && tev[irq_trap_pkg::T_STACK] && !dev_rst
		|=> core_o.halt && s.tpend[irq_trap_pkg::T_STACK])
		else $error("hard trap did not halt");
	flushed_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cause_set == 8'h00 |=> !core_o.dreset)
		else $error("reset without a cause");
endmodule

// [hw/irq_trap_pkg.sv]
// constants and carrier types for the interrupt and trap prioritizer
package irq_trap_pkg;
	// ==========================================================
	// source and vector geometry
	localparam int         NSRC       = 45;
	localparam int         NPRIO      = 48;
	localparam int         NGRP       = 12;
	localparam logic [2:0] PRIO_RST   = 3'h4;
	localparam logic [5:0] VEC_BASE   = 6'h08;
	// reserved interrupt numbers have a zero here
	localparam logic [44:0] SRC_IMPL  = 45'h19BF3CF9FFFF;
	localparam logic [23:0] RESET_PC  = 24'h000000;
	// ==========================================================
	// register word indices, byte address is index times four
	localparam logic [5:0] IDX_FLAG_LO = 6'h0C;
	localparam logic [5:0] IDX_FLAG_HI = 6'h0D;
	localparam logic [5:0] IDX_EN_LO   = 6'h0E;
	localparam logic [5:0] IDX_EN_HI   = 6'h0F;
	localparam logic [5:0] IDX_CTRL    = 6'h10;
	localparam logic [5:0] IDX_STAT    = 6'h11;
	localparam logic [5:0] IDX_STACK_LIMIT_VALUE   = 6'h12;
	// control bits
	localparam int CTRL_NEST  = 0;
	localparam int CTRL_OVF31 = 1;
	localparam int CTRL_OVF39 = 2;
	// reset cause bits, held in status bits 15:8
	localparam int CAUSE_WDT   = 0;
	localparam int CAUSE_UNINIT = 1;
	localparam int CAUSE_ILL   = 2;
	localparam int CAUSE_BOR   = 3;
	localparam int CAUSE_CONF  = 7;
	// ==========================================================
	// traps: index 0..3 stands for level 11..14
	localparam int         T_MATH        = 0;
	localparam int         T_ADDR        = 1;
	localparam int         T_STACK       = 2;
	localparam int         T_OSC         = 3;
	localparam logic [3:0] TRAP_LVL_BASE = 4'hB;
	localparam logic [15:0] STACK_LIMIT_VALUE_RST    = 16'hFFFE;
	localparam logic [15:0] STACK_FLOOR  = 16'h0800;
	// ==========================================================
	// fault and reset conditions reported by the core
	typedef struct packed {
		logic        div_zero;
		logic        acc_ovf31;
		logic        guard_used;
		logic        acc_ovf39;
		logic        sat_on;
		logic        shift_over;
		logic        misalign;
		logic        unimpl_data;
		logic        unimpl_prog;
		logic        vec_fetch;
		logic        bad_branch;
		logic        bad_pc;
		logic        mac_x;
		logic        mac_y;
		logic        in_x;
		logic        in_y;
		logic        sp_load;
		logic [15:0] sp_value;
		logic        osc_fail;
		logic        wdt;
		logic        uninit_w;
		logic        ill_exec;
		logic        ill_flushed;
		logic        brown_out;
	} fault_t;
	// requests presented to the core
	typedef struct packed {
		logic       irq;
		logic [5:0] vec;
		logic [2:0] lvl;
		logic       treq;
		logic [3:0] tlvl;
		logic       halt;
		logic       tflag;
		logic       dreset;
		logic       div_abort;
	} core_req_t;
endpackage

// [hw/sticky_flags.sv]
// bank of sticky flags, a set beats a clear in the same cycle
`timescale 1ns/1ns
module sticky_flags #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] q;
	} fl_t;
	fl_t s;
	fl_t next_s;
	// clear first, then set so an event is never lost
	always_comb begin
		next_s.q = (s.q & ~clr_i) | set_i;
	end
	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end
	assign q_o = s.q;
endmodule

// [hw/irq_arbiter.sv]
// picks the highest priority pending source, lowest number on a tie
`timescale 1ns/1ns
module irq_arbiter (
	input  wire logic [44:0]       req_i,
	input  wire logic [47:0][2:0]  prio_i,
	output logic                   found_o,
	output logic      [5:0]        num_o,
	output logic      [2:0]        lvl_o
);
	// scan downward; >= lets a lower number win a tie
	always_comb begin
		found_o = 1'b0;
		num_o   = 6'h00;
		lvl_o   = 3'h0;
		for (int i = irq_trap_pkg::NSRC - 1; i >= 0; i--) begin
			if (req_i[i] && (!found_o || prio_i[i] >= lvl_o)) begin
				found_o = 1'b1;
				num_o   = 6'(i);
				lvl_o   = prio_i[i];
			end
		end
	end
endmodule

// [tb/core_side_model.sv]
// behavioural processor core that takes and retires trap requests
`timescale 1ns/1ns
module core_side_model (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    serve_i,
	input  wire logic                    slow_i,
	input  wire irq_trap_pkg::core_req_t core_i,
	output logic                         instr_done_o,
	output logic                         trap_ack_o,
	output logic                         trap_done_o,
	output logic                         take_o
);
	logic [1:0] ph;
	logic [3:0] gap;
	logic [3:0] dn;
	// ==========================================================
	// boundaries every cycle, or one in four when the core is slow
	assign instr_done_o = slow_i ? (ph == 2'h0) : 1'b1;
	// a new trap only once the previous one has had time to retire
	assign take_o = core_i.treq && serve_i && (gap == 4'h0);
	// ack at once, return four cycles later, never both together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph <= 2'h0;
			gap <= 4'h0;
			dn <= 4'h0;
			trap_ack_o <= 1'b0;
			trap_done_o <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			trap_ack_o <= take_o;
			trap_done_o <= (dn == 4'h1);
			gap <= take_o ? 4'h6 : gap - (gap != 4'h0);
			dn <= take_o ? 4'h4 : dn - (dn != 4'h0);
		end
	end
endmodule

// [tb/interrupt_trap_prioritizer_tb_top.sv]
// self-checking bench for the interrupt and trap prioritizer
`timescale 1ns/1ns
module interrupt_trap_prioritizer_tb_top;
	logic                    clk_i = 1'b0;
	logic                    rst_i = 1'b1;
	logic                    cyc_i = 1'b0;
	logic                    stb_i = 1'b0;
	logic                    we_i = 1'b0;
	logic [7:0]              adr_i = 8'h00;
	logic [3:0]              sel_i = 4'hF;
	logic [31:0]             dat_i = 32'h00000000;
	logic [31:0]             dat_o;
	logic                    ack_o;
	logic [44:0]             irq_src_i = '0;
	logic [3:0]              cpu_level_i = 4'h0;
	logic                    in_service_i = 1'b0;
	irq_trap_pkg::fault_t    fault_i = '0;
	irq_trap_pkg::core_req_t core_o;
	logic                    instr_done, trap_ack, trap_done, take;
	logic                    serve = 1'b0;
	logic                    slow = 1'b0;
	logic                    ce = 1'b1;
	logic                    probe = 1'b0;
	logic                    prev_done = 1'b0;
	logic [31:0]             seed = 32'h00014323;
	logic [9:0]              e;
	logic [2:0]              pr [48];
	logic [31:0]             rd_q [$];
	logic [9:0]              cr_q [$];
	logic [3:0]              tl_q [$];
	int                      fails = 0, n_checks = 0;
	int                      dres = 0, exp_dres = 0, dab = 0;
	// expected status and served trap levels per fault case
	localparam logic [15:0] est [24] = '{16'h0001, 16'h0001, 16'h0000,
		16'h0001, 16'h0000, 16'h0001, 16'h0002, 16'h0002, 16'h0002,
		16'h0002, 16'h0002, 16'h0000, 16'h0004, 16'h0000, 16'h0008,
		16'h000A, 16'h0100, 16'h0200, 16'h0400, 16'h0000, 16'h0800,
		16'h8000, 16'h0004, 16'h0000};
	localparam logic [7:0] elv [24] = '{8'hB0, 8'hB0, 8'h00, 8'hB0,
		8'h00, 8'hB0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h00, 8'hD0,
		8'h00, 8'hE0, 8'hEC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hD0, 8'h00};

	interrupt_trap_prioritizer u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .irq_src_i(irq_src_i), .cpu_level_i(cpu_level_i),
		.in_service_i(in_service_i), .instr_done_i(instr_done),
		.trap_ack_i(trap_ack), .trap_done_i(trap_done),
		.fault_i(fault_i), .core_o(core_o));
	core_side_model u_core (.clk_i(clk_i), .rst_i(rst_i), .serve_i(serve),
		.slow_i(slow), .core_i(core_o), .instr_done_o(instr_done),
		.trap_ack_o(trap_ack), .trap_done_o(trap_done), .take_o(take));

	// ==========================================================
	// clock, verdict and hang guard
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task wrap_up();
		if (fails == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		wrap_up();
	end
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask
	function automatic logic [31:0] nx();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed;
	endfunction
	// ==========================================================
	// watcher: takes the oldest note whenever a result shows up
	always @(posedge clk_i) begin
		prev_done <= instr_done;
		if (ack_o === 1'b1 && !we_i && rd_q.size() > 0)
			chk("read data", rd_q.pop_front(), dat_o);
		if (probe) begin
			e = cr_q.pop_front();
			chk("irq", {31'h0, e[9]}, {31'h0, core_o.irq});
			if (e[9])
				chk("vector level", {22'h0, e[8:0]}, {core_o.vec, core_o.lvl});
		end
		if (take === 1'b1 && tl_q.size() > 0)
			chk("trap level", tl_q.pop_front(), core_o.tlvl);
		if (core_o.treq === 1'b1)
			chk("boundary", 1, prev_done);
		if (trap_done === 1'b1)
			chk("trap flag", 1, core_o.tflag);
		// a pending interrupt must stay hidden while the core resets
		if (core_o.dreset === 1'b1) begin
			dres++;
			chk("irq in reset", 0, core_o.irq);
		end
		if (core_o.div_abort === 1'b1) dab++;
	end
	// ==========================================================
	// wishbone classic master: hold until ack, then release
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 16);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 16) fails++;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ex);
		rd_q.push_back(ex);
		wb(1'b0, a, 32'h0);
	endtask
	task probe_core(input logic [9:0] ex);
		cr_q.push_back(ex);
		repeat (3) @(posedge clk_i);
		probe <= 1'b1;
		@(posedge clk_i);
		probe <= 1'b0;
	endtask
	task pulse(input logic [44:0] s);
		@(posedge clk_i);
		irq_src_i <= s;
		@(posedge clk_i);
		irq_src_i <= '0;
	endtask
	task pf(input irq_trap_pkg::fault_t f);
		@(posedge clk_i);
		fault_i <= f;
		@(posedge clk_i);
		fault_i <= '0;
	endtask
	// ==========================================================
	// fault cases, one condition or a pair per case
	function automatic irq_trap_pkg::fault_t mk(input int i);
		irq_trap_pkg::fault_t f;
		f = '0;
		case (i)
			0: f.div_zero = 1'b1;
			1: f.acc_ovf31 = 1'b1;
			2: {f.acc_ovf31, f.guard_used} = 2'h3;
			3: f.acc_ovf39 = 1'b1;
			4: {f.acc_ovf39, f.sat_on} = 2'h3;
			5: f.shift_over = 1'b1;
			6: f.misalign = 1'b1;
			7: f.unimpl_data = 1'b1;
			8: f.vec_fetch = 1'b1;
			9: f.bad_branch = 1'b1;
			10: {f.mac_x, f.in_y} = 2'h3;
			11: {f.mac_x, f.in_x} = 2'h3;
			12: {f.sp_load, f.sp_value} = 17'h107FE;
			13: {f.sp_load, f.sp_value} = 17'h10800;
			15: {f.misalign, f.osc_fail} = 2'h3;
			16: f.wdt = 1'b1;
			17: f.uninit_w = 1'b1;
			18: f.ill_exec = 1'b1;
			19: {f.ill_exec, f.ill_flushed} = 2'h3;
			20: f.brown_out = 1'b1;
			22: {f.sp_load, f.sp_value} = 17'h11002;
			23: {f.sp_load, f.sp_value} = 17'h11000;
			default: f.osc_fail = 1'b1;
		endcase
		return f;
	endfunction
	// case 21 adds a lower hard trap while the oscillator one is held
	task trap_case(input int i);
		slow <= i[0];
		pf(mk(i));
		if (i == 21) pf(mk(6));
		rd(8'h44, {16'h0, est[i]});
		chk("halt", {31'h0, |est[i][3:1]}, {31'h0, core_o.halt});
		if (elv[i][7:4] != 4'h0) tl_q.push_back(elv[i][7:4]);
		if (elv[i][3:0] != 4'h0) tl_q.push_back(elv[i][3:0]);
		serve <= 1'b1;
		repeat (40) @(posedge clk_i);
		serve <= 1'b0;
		wb(1'b1, 8'h44, 32'h0000FF00);
		rd(8'h44, 32'h0);
		if (est[i][15:8] != 8'h00) exp_dres++;
		chk("reset pulses", exp_dres, dres);
	endtask
	// random priorities, sources and cpu level against a reference pick
	task rand_case();
		logic [63:0] r;
		logic [31:0] v;
		int b;
		for (int g = 0; g < 12; g++) begin
			v = nx();
			wb(1'b1, 8'(g * 4), v);
			for (int k = 0; k < 4; k++) pr[g * 4 + k] = v[k * 4 +: 3];
		end
		wb(1'b1, 8'h30, 32'hFFFFFFFF);
		wb(1'b1, 8'h34, 32'hFFFFFFFF);
		r = {nx(), nx()} & {nx(), nx()};
		v = nx();
		cpu_level_i <= {1'b0, v[2:0]};
		pulse(r[44:0]);
		b = -1;
		for (int n = 0; n < 45; n++)
			if (r[n] && irq_trap_pkg::SRC_IMPL[n] && (b < 0 || pr[n] > pr[b]))
				b = n;
		if (b >= 0 && pr[b] > v[2:0]) probe_core({1'b1, 6'(b + 8), pr[b]});
		else probe_core(10'h0);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, 32'h00004444);
		wb(1'b1, 8'h00, 32'hFFFFFFFF);
		rd(8'h00, 32'h00007777);
		wb(1'b1, 8'h80, 32'hFFFFFFFF);
		rd(8'h80, 32'h00000000);
		rd(8'h48, 32'h0000FFFE);
		pulse(45'h000000020008);
		rd(8'h30, 32'h00000008);
		probe_core(10'h000);
		wb(1'b1, 8'h38, 32'h00000008);
		probe_core({1'b1, 6'h0B, 3'h7});
		wb(1'b1, 8'h38, 32'hFFFFFFFF);
		wb(1'b1, 8'h3C, 32'h00001FFF);
		repeat (8) rand_case();
		wb(1'b1, 8'h00, 32'h00000007);
		cpu_level_i <= 4'h0;
		pulse(45'h1);
		probe_core({1'b1, 6'h08, 3'h7});
		cpu_level_i <= 4'h7;
		probe_core(10'h000);
		cpu_level_i <= 4'h0;
		in_service_i <= 1'b1;
		wb(1'b1, 8'h40, 32'h00000001);
		probe_core(10'h000);
		in_service_i <= 1'b0;
		probe_core({1'b1, 6'h08, 3'h7});
		wb(1'b1, 8'h40, 32'h00000006);
		// frozen clock enable: a source event must leave no flag
		wb(1'b1, 8'h30, 32'hFFFFFFFF);
		wb(1'b1, 8'h34, 32'h00001FFF);
		ce <= 1'b0;
		pulse(45'h1);
		ce <= 1'b1;
		probe_core(10'h000);
		pulse(45'h1);
		probe_core({1'b1, 6'h08, 3'h7});
		for (int i = 0; i < 22; i++) trap_case(i);
		wb(1'b1, 8'h48, 32'h00001000);
		rd(8'h48, 32'h00001000);
		trap_case(22);
		trap_case(23);
		chk("divide aborts", 1, dab);
		wrap_up();
	end
endmodule
